/* File: cap_sense_pkg.sv */
package cap_sense_pkg;

  // Power modes of the sensing oscillator
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_LOW,
    MODE_MED,
    MODE_HIGH,
    MODE_NOISE
  } mode_e;

  // Bus geometry
  localparam int          AXI_ADDR_W      = 8;
  localparam int          AXI_DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Register byte offsets
  localparam logic [7:0]  OFF_SENSE_CTRL0 = 8'h00;
  localparam logic [7:0]  OFF_TIMER0_CFG  = 8'h04;
  localparam logic [7:0]  OFF_TIMER1_CTRL = 8'h08;
  localparam logic [7:0]  OFF_GATE_CTRL   = 8'h0C;
  localparam logic [7:0]  OFF_TIMER0_CNT  = 8'h10;
  localparam logic [7:0]  OFF_TIMER1_CNT  = 8'h14;
  localparam logic [7:0]  OFF_EVENT_STAT  = 8'h18;

  // sense_control_reg0 fields
  localparam int          BIT_MODULE_EN   = 7;
  localparam int          BIT_REF_MODE    = 6;
  localparam int          BIT_RANGE_HI    = 3;
  localparam int          BIT_RANGE_LO    = 2;
  localparam int          BIT_OSC_DIR     = 1;
  localparam int          BIT_T0_EXT_SEL  = 0;

  // Timer0 config field
  localparam int          BIT_T0_CLK_SRC  = 0;

  // timer1_control_reg fields
  localparam int          BIT_T1_CS_HI    = 7;
  localparam int          BIT_T1_CS_LO    = 6;
  localparam int          BIT_T1_RUN      = 0;

  // Gate control field
  localparam int          BIT_T1_GATE_EN  = 0;

  // Event status fields, write one to clear
  localparam int          BIT_T0_OVF      = 0;
  localparam int          BIT_NOISE_ACT   = 1;

  // Current range and Timer1 source codes
  localparam logic [1:0]  RANGE_ZERO      = 2'h0;
  localparam logic [1:0]  RANGE_LOW       = 2'h1;
  localparam logic [1:0]  RANGE_MED       = 2'h2;
  localparam logic [1:0]  RANGE_HIGH      = 2'h3;
  localparam logic [1:0]  T1_SRC_QUARTER  = 2'h0;
  localparam logic [1:0]  T1_SRC_SYSCLK   = 2'h1;
  localparam logic [1:0]  T1_SRC_PIN      = 2'h2;
  localparam logic [1:0]  T1_SRC_OSC      = 2'h3;

  // Reset values and timing
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [1:0]  QUARTER_LAST    = 2'h3;
  localparam int          T0_WIDTH        = 8;
  localparam int          T1_WIDTH        = 16;

endpackage : cap_sense_pkg

/* File: count_if.sv */
`timescale 1ns/1ps
interface count_if #(parameter int WIDTH = 8);
  logic             inc;
  logic             load;
  logic [WIDTH-1:0] load_val;
  logic [WIDTH-1:0] value;
  logic             ovf;

  modport ctrl    (output inc, output load, output load_val, input value, input ovf);
  modport counter (input inc, input load, input load_val, output value, output ovf);
endinterface : count_if

/* File: edge_counter.sv */
`timescale 1ns/1ps
module edge_counter (
  input  wire logic   clk,
  input  wire logic   nrst,
  count_if.counter    cnt
);
  import cap_sense_pkg::*;

  // Bus load wins over a count in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt.value <= '0;
    end else if (cnt.load) begin
      cnt.value <= cnt.load_val;
    end else if (cnt.inc) begin
      cnt.value <= cnt.value + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt.ovf <= 1'b0;
    end else begin
      cnt.ovf <= cnt.inc && !cnt.load && (&cnt.value);
    end
  end

endmodule : edge_counter

/* File: cap_sense_ctrl.sv */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// RULE1 - Reference mode bit picks fixed internal or variable external threshold references.
// RULE2 - Range field 01/10/11 gives low/medium/high current; 00 in low range is off.
// RULE3 - High range with field 00 is noise mode: no pin current, oscillator still active.
// RULE4 - In noise mode pin noise toggles the comparator, flagged as activity.
// RULE5 - Oscillator output clocks exactly one of Timer0 or Timer1.
// RULE6 - Software never times the measurement with the timer the oscillator clocks.
// RULE7 - Timer0 ext select set and clock source cleared makes Timer0 count oscillator; here not while Timer1 clock select is 11.
// RULE8 - Timer1 clock select 11 makes Timer1 count the oscillator.
// RULE9 - Timer1 off without run; with run, free or gated by gate enable.
// RULE10 - Software should build the time base from Timer0 overflow and Timer1 gate toggle.
// RULE11 - Software clears the timer at time base start and captures it at end.
// RULE12 - Frequency is count over period, same time base loaded and unloaded.
// RULE13 - Software should place the touch threshold midway between both frequencies.
// RULE14 - Bit 7 of control register 0 enables the sensing module.
// RULE15 - Read-only bit 1 shows 1 while sourcing and 0 while sinking current.
// RULE16 - Oscillator output is synchronised before it enables timer counting.
module cap_sense_ctrl (
  input  wire logic                               REF_CLK,
  input  wire logic                               NRST,
  input  wire logic [cap_sense_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic [2:0]                         S_AXI_AWPROT,
  input  wire logic                               S_AXI_AWVALID,
  output logic                                    S_AXI_AWREADY,
  input  wire logic [cap_sense_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]                         S_AXI_WSTRB,
  input  wire logic                               S_AXI_WVALID,
  output logic                                    S_AXI_WREADY,
  output logic [1:0]                              S_AXI_BRESP,
  output logic                                    S_AXI_BVALID,
  input  wire logic                               S_AXI_BREADY,
  input  wire logic [cap_sense_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic [2:0]                         S_AXI_ARPROT,
  input  wire logic                               S_AXI_ARVALID,
  output logic                                    S_AXI_ARREADY,
  output logic [cap_sense_pkg::AXI_DATA_W-1:0]    S_AXI_RDATA,
  output logic [1:0]                              S_AXI_RRESP,
  output logic                                    S_AXI_RVALID,
  input  wire logic                               S_AXI_RREADY,
  input  wire logic                               OSC_IN,
  input  wire logic                               TIMER0_PIN,
  input  wire logic                               TIMER1_PIN,
  input  wire logic                               GATE_IN,
  output logic                                    REF_SEL_VARIABLE,
  output cap_sense_pkg::mode_e                    CURRENT_MODE,
  output logic                                    OSC_ENABLE,
  output logic                                    SOURCE_ENABLE
);
  import cap_sense_pkg::*;

  logic [7:0]            ctrl0_reg;
  logic                  t0_cfg_reg;
  logic [7:0]            t1_ctrl_reg;
  logic                  gate_en_reg;
  logic [1:0]            stat_reg;
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [AXI_DATA_W-1:0] wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  osc_meta_reg;
  logic                  osc_sync_reg;
  logic                  osc_prev_reg;
  logic                  pin0_prev_reg;
  logic                  pin1_prev_reg;
  logic [1:0]            quarter_reg;
  mode_e                 mode_next;
  logic                  wr_fire;
  logic [AXI_ADDR_W-1:0] wr_word;
  logic [AXI_ADDR_W-1:0] rd_word;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [AXI_DATA_W-1:0] rd_data;
  logic                  module_en;
  logic                  osc_edge;
  logic                  quarter_tick;
  logic                  t0_osc;
  logic                  t1_osc;
  logic                  t1_src_tick;
  logic                  t1_counting;

  count_if #(.WIDTH(T0_WIDTH)) t0_if ();
  count_if #(.WIDTH(T1_WIDTH)) t1_if ();

  edge_counter u_timer0 (
    .clk  (REF_CLK),
    .nrst (NRST),
    .cnt  (t0_if.counter)
  );

  edge_counter u_timer1 (
    .clk  (REF_CLK),
    .nrst (NRST),
    .cnt  (t1_if.counter)
  );

  // Bus write channel: address and data taken in either order
  assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held_reg && !S_AXI_BVALID;
  assign wr_fire       = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign wr_word       = {awaddr_reg[AXI_ADDR_W-1:2], 2'b00};
  assign rd_word       = {S_AXI_ARADDR[AXI_ADDR_W-1:2], 2'b00};

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= S_AXI_WDATA;
      wstrb_reg  <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    case (wr_word)
      OFF_SENSE_CTRL0, OFF_TIMER0_CFG, OFF_TIMER1_CTRL, OFF_GATE_CTRL,
      OFF_TIMER0_CNT, OFF_TIMER1_CNT, OFF_EVENT_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Control registers; only lane 0 carries them
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      ctrl0_reg   <= RST_BYTE;
      t0_cfg_reg  <= 1'b0;
      t1_ctrl_reg <= RST_BYTE;
      gate_en_reg <= 1'b0;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (wr_word)
        OFF_SENSE_CTRL0: ctrl0_reg   <= wdata_reg[7:0] & 8'hCD;
        OFF_TIMER0_CFG:  t0_cfg_reg  <= wdata_reg[BIT_T0_CLK_SRC];
        OFF_TIMER1_CTRL: t1_ctrl_reg <= wdata_reg[7:0] & 8'hC1;
        OFF_GATE_CTRL:   gate_en_reg <= wdata_reg[BIT_T1_GATE_EN];
        default: ;
      endcase
    end
  end

  // Counter loads let software clear at time base start
  assign t0_if.load     = wr_fire && wstrb_reg[0] && (wr_word == OFF_TIMER0_CNT);
  assign t0_if.load_val = wdata_reg[7:0];
  assign t1_if.load     = wr_fire && (|wstrb_reg[1:0]) && (wr_word == OFF_TIMER1_CNT);
  assign t1_if.load_val = {wstrb_reg[1] ? wdata_reg[15:8] : t1_if.value[15:8],
                           wstrb_reg[0] ? wdata_reg[7:0]  : t1_if.value[7:0]};

  // Sticky events; a new event beats the clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      stat_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == BIT_T0_OVF && t0_if.ovf) ||
            (i == BIT_NOISE_ACT && osc_edge && CURRENT_MODE == MODE_NOISE)) begin // RULE4
          stat_reg[i] <= 1'b1;
        end else if (wr_fire && wstrb_reg[0] && wr_word == OFF_EVENT_STAT && wdata_reg[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Bus read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    case (rd_word)
      OFF_SENSE_CTRL0: rd_data[7:0] = {ctrl0_reg[7:2], osc_sync_reg, ctrl0_reg[0]}; // RULE15
      OFF_TIMER0_CFG:  rd_data[BIT_T0_CLK_SRC] = t0_cfg_reg;
      OFF_TIMER1_CTRL: rd_data[7:0] = t1_ctrl_reg;
      OFF_GATE_CTRL:   rd_data[BIT_T1_GATE_EN] = gate_en_reg;
      OFF_TIMER0_CNT:  rd_data[T0_WIDTH-1:0] = t0_if.value;
      OFF_TIMER1_CNT:  rd_data[T1_WIDTH-1:0] = t1_if.value;
      OFF_EVENT_STAT:  rd_data[1:0] = stat_reg;
      default:         rd_hit = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_data;
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Oscillator mode decode
  assign module_en = ctrl0_reg[BIT_MODULE_EN]; // RULE14

  always_comb begin
    mode_next = MODE_OFF;
    if (module_en) begin
      case (ctrl0_reg[BIT_RANGE_HI:BIT_RANGE_LO]) // RULE2
        RANGE_LOW:  mode_next = MODE_LOW;
        RANGE_MED:  mode_next = MODE_MED;
        RANGE_HIGH: mode_next = MODE_HIGH;
        default:    mode_next = ctrl0_reg[BIT_REF_MODE] ? MODE_NOISE : MODE_OFF; // RULE3
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      CURRENT_MODE     <= MODE_OFF;
      REF_SEL_VARIABLE <= 1'b0;
      OSC_ENABLE       <= 1'b0;
      SOURCE_ENABLE    <= 1'b0;
    end else begin
      CURRENT_MODE     <= mode_next;
      REF_SEL_VARIABLE <= ctrl0_reg[BIT_REF_MODE]; // RULE1
      OSC_ENABLE       <= (mode_next != MODE_OFF);
      SOURCE_ENABLE    <= (mode_next != MODE_OFF) && (mode_next != MODE_NOISE); // RULE3
    end
  end

  // Comparator output is asynchronous; only the second stage is looked at
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= OSC_IN; // RULE16
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // Edges above half of REF_CLK are lost
  assign osc_edge = osc_sync_reg && !osc_prev_reg && module_en; // RULE16

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      pin0_prev_reg <= 1'b0;
      pin1_prev_reg <= 1'b0;
      quarter_reg   <= 2'b00;
    end else begin
      pin0_prev_reg <= TIMER0_PIN;
      pin1_prev_reg <= TIMER1_PIN;
      quarter_reg   <= quarter_reg + 2'b01;
    end
  end

  assign quarter_tick = (quarter_reg == QUARTER_LAST);

  // Timer1 takes the oscillator when both ask for it
  assign t1_osc = (t1_ctrl_reg[BIT_T1_CS_HI:BIT_T1_CS_LO] == T1_SRC_OSC); // RULE8
  assign t0_osc = ctrl0_reg[BIT_T0_EXT_SEL] && !t0_cfg_reg && !t1_osc; // RULE5 RULE7

  always_comb begin
    if (t0_cfg_reg) begin
      t0_if.inc = TIMER0_PIN && !pin0_prev_reg;
    end else if (t0_osc) begin
      t0_if.inc = osc_edge; // RULE7
    end else begin
      t0_if.inc = quarter_tick && !ctrl0_reg[BIT_T0_EXT_SEL];
    end
  end

  always_comb begin
    case (t1_ctrl_reg[BIT_T1_CS_HI:BIT_T1_CS_LO])
      T1_SRC_QUARTER: t1_src_tick = quarter_tick;
      T1_SRC_SYSCLK:  t1_src_tick = 1'b1;
      T1_SRC_PIN:     t1_src_tick = TIMER1_PIN && !pin1_prev_reg;
      default:        t1_src_tick = osc_edge; // RULE8
    endcase
  end

  assign t1_counting = t1_ctrl_reg[BIT_T1_RUN] && (!gate_en_reg || GATE_IN); // RULE9
  assign t1_if.inc   = t1_counting && t1_src_tick; // RULE9

  // Checks
  sequence s_noise_cfg;
    module_en && ctrl0_reg[BIT_REF_MODE] && ctrl0_reg[BIT_RANGE_HI:BIT_RANGE_LO] == RANGE_ZERO;
  endsequence

  sequence s_osc_rise_at_pin;
    !OSC_IN ##1 OSC_IN;
  endsequence

  a_ref_follow: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE1
    ##1 REF_SEL_VARIABLE == $past(ctrl0_reg[BIT_REF_MODE]))
    else $error("Reference select does not follow mode bit");

  a_noise_mode: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE3
    s_noise_cfg |=> CURRENT_MODE == MODE_NOISE && OSC_ENABLE && !SOURCE_ENABLE)
    else $error("Noise mode not entered or pin current left on");

  a_low_off: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE2
    !ctrl0_reg[BIT_REF_MODE] && ctrl0_reg[BIT_RANGE_HI:BIT_RANGE_LO] == RANGE_ZERO
    |=> CURRENT_MODE == MODE_OFF && !OSC_ENABLE)
    else $error("Low range code zero did not turn oscillator off");

  a_range_med: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE2
    module_en && ctrl0_reg[BIT_RANGE_HI:BIT_RANGE_LO] == RANGE_MED
    |=> CURRENT_MODE == MODE_MED && SOURCE_ENABLE)
    else $error("Medium range code decoded wrongly");

  a_disable_off: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE14
    !module_en |-> !osc_edge ##1 !OSC_ENABLE)
    else $error("Disabled module still active");

  a_one_timer: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE5
    t1_osc && ctrl0_reg[BIT_T0_EXT_SEL] && !t0_cfg_reg && !t0_if.load
    |=> t0_if.value == $past(t0_if.value))
    else $error("Oscillator routed to both timers");

  a_t1_stop: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE9
    (!t1_ctrl_reg[BIT_T1_RUN] || (gate_en_reg && !GATE_IN)) && !t1_if.load
    |=> t1_if.value == $past(t1_if.value))
    else $error("Timer1 counted while stopped or gated");

  a_t1_osc_count: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE8
    t1_osc && t1_ctrl_reg[BIT_T1_RUN] && !gate_en_reg && osc_edge && !t1_if.load
    |=> t1_if.value == $past(t1_if.value) + 16'h0001)
    else $error("Timer1 missed an oscillator edge");

  a_sync_delay: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE16
    s_osc_rise_at_pin ##0 (module_en && OSC_IN) [*3] |-> osc_edge)
    else $error("Oscillator edge not seen two cycles after pin");

  a_edge_origin: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE16
    osc_edge |-> $past(OSC_IN, 2) && !$past(OSC_IN, 3))
    else $error("Oscillator edge without synchronised pin rise");

  a_t0_osc_count: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE7
    t0_osc && osc_edge && !t0_if.load |=> t0_if.value == $past(t0_if.value) + 8'h01)
    else $error("Timer0 missed an oscillator edge");

endmodule : cap_sense_ctrl

/* File: touch_pad.sv */
`timescale 1ns/1ps
module touch_pad (
  input  wire logic       clk,
  input  wire logic       osc_en,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic       loaded,
  input  wire logic       park,
  output logic            osc,
  output logic            busy
);
  logic [7:0] left = 8'h00;
  logic [3:0] ph   = 4'h0;
  logic       lvl  = 1'b0;
  logic [3:0] half;
  // Finger load slows the triangle, so the comparator half period grows
  assign half = loaded ? 4'h5 : 4'h3;
  always_ff @(posedge clk) begin
    if (start) begin
      left <= pulses;
      ph   <= 4'h0;
      lvl  <= 1'b0;
    end else if (left != 8'h00) begin
      ph <= (ph == half - 4'h1) ? 4'h0 : ph + 4'h1;
      if (ph == half - 4'h1) begin
        lvl <= !lvl;
        if (lvl) left <= left - 8'h01;
      end
    end
  end
  assign busy = (left != 8'h00);
  // Swing or injected noise reaches the comparator only while the oscillator is active
  assign osc = osc_en ? (busy ? lvl : park) : 1'b0;
endmodule : touch_pad

/* File: capacitive_sense_mode_and_timer_select_bench.sv */
`timescale 1ns/1ps
module capacitive_sense_mode_and_timer_select_bench;
  import cap_sense_pkg::*;
  logic        REF_CLK, NRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        S_AXI_RREADY, OSC_IN, TIMER0_PIN, TIMER1_PIN, GATE_IN;
  logic        REF_SEL_VARIABLE, OSC_ENABLE, SOURCE_ENABLE, pstart, pbusy, pload, park;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, pcount, n;
  logic [2:0]  S_AXI_AWPROT, S_AXI_ARPROT;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  mode_e       CURRENT_MODE, em;
  logic [1:0]  wq [$];
  logic [33:0] rq [$];
  logic [7:0]  regs  [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
  logic [2:0]  gcase [5] = '{3'b100, 3'b110, 3'b111, 3'b001, 3'b011};
  int          n_fail = 0;
  int          n_compared = 0;
  logic [2:0]  osc_hist;
  logic [15:0] ref_cnt, meas [2];
  logic [16:0] thr;

  cap_sense_ctrl cap_sense_ctrl_i (.REF_CLK, .NRST, .S_AXI_AWADDR, .S_AXI_AWPROT,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARPROT, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .OSC_IN, .TIMER0_PIN, .TIMER1_PIN, .GATE_IN,
    .REF_SEL_VARIABLE, .CURRENT_MODE, .OSC_ENABLE, .SOURCE_ENABLE);
  touch_pad touch_pad_i (.clk(REF_CLK), .osc_en(OSC_ENABLE), .start(pstart),
    .pulses(pcount), .loaded(pload), .park(park), .osc(OSC_IN), .busy(pbusy));

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // Ready lines stay high, so the only handshake the tasks wait on is valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    wq.push_back(e);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
  endtask : rd

  // Fixed pulse bursts stand in for a time base kept apart from the counting timer
  task automatic burst(input logic [7:0] cnt, input logic ld);
    pcount <= cnt;
    pload  <= ld;
    pstart <= 1'b1;
    @(posedge REF_CLK);
    pstart <= 1'b0;
    @(posedge REF_CLK);
    while (pbusy) @(posedge REF_CLK);
    repeat (6) @(posedge REF_CLK);
  endtask : burst

  always @(posedge REF_CLK) begin
    if (S_AXI_BVALID && S_AXI_BREADY) chk({32'h0, S_AXI_BRESP}, {32'h0, wq.pop_front()});
    if (S_AXI_RVALID && S_AXI_RREADY) chk({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
  end

  // Pad rises seen through the two-stage delay while the gate is open
  always @(posedge REF_CLK) begin
    osc_hist <= {osc_hist[1:0], OSC_IN};
    if (pstart) ref_cnt <= 16'h0;
    else if (GATE_IN && osc_hist[1] && !osc_hist[2]) ref_cnt <= ref_cnt + 16'h1;
  end

  initial begin
    repeat (30000) @(posedge REF_CLK);
    n_fail++;
    end_sim();
  end

  initial begin
    NRST = 1'b0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, GATE_IN, pstart, pload, park} = 7'h00;
    {S_AXI_BREADY, S_AXI_RREADY} = 2'h3;
    {S_AXI_AWADDR, S_AXI_ARADDR, pcount} = 24'h0;
    {S_AXI_AWPROT, S_AXI_ARPROT, TIMER0_PIN, TIMER1_PIN} = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    void'($urandom(32'haad5a52c));
    repeat (12) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    chk({REF_SEL_VARIABLE, CURRENT_MODE, OSC_ENABLE, SOURCE_ENABLE}, 34'h0);
    foreach (regs[i]) rd(regs[i], 34'h0);
    wr(8'h1C, $urandom, RESP_SLVERR);
    rd(8'h1C, {RESP_SLVERR, 32'h0});
    $display("test reset and map done");

    for (int i = 0; i < 16; i++) begin
      em = !i[3] ? MODE_OFF : (i[1:0] == RANGE_ZERO) ? (i[2] ? MODE_NOISE : MODE_OFF)
                                                     : mode_e'(i[1:0]);
      wr(OFF_SENSE_CTRL0, {24'h0, i[3], i[2], 2'b00, i[1:0], 2'b00}, RESP_OKAY);
      repeat (2) @(posedge REF_CLK);
      chk(CURRENT_MODE, em);
      chk({OSC_ENABLE, SOURCE_ENABLE}, {em != MODE_OFF, em inside {MODE_LOW, MODE_MED, MODE_HIGH}});
      chk(REF_SEL_VARIABLE, i[2]);
      rd(OFF_SENSE_CTRL0, {26'h0, i[3], i[2], 2'b00, i[1:0], 2'b00});
    end
    $display("test mode decode done");

    n = 8'(5 + $urandom % 30);
    wr(OFF_TIMER1_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_TIMER0_CFG, 32'h0, RESP_OKAY);
    wr(OFF_SENSE_CTRL0, 32'h8D, RESP_OKAY);
    wr(OFF_TIMER0_CNT, 32'h0, RESP_OKAY);
    burst(n, 1'b0);
    rd(OFF_TIMER0_CNT, {26'h0, n});
    wr(OFF_TIMER0_CNT, 32'h0, RESP_OKAY);
    burst(n, 1'b1);
    rd(OFF_TIMER0_CNT, {26'h0, n});
    wr(OFF_TIMER0_CFG, 32'h1, RESP_OKAY);
    burst(n, 1'b0);
    rd(OFF_TIMER0_CNT, {26'h0, n});
    rd(OFF_TIMER1_CNT, 34'h0);
    $display("test timer0 count done");

    wr(OFF_TIMER0_CFG, 32'h0, RESP_OKAY);
    wr(OFF_TIMER0_CNT, 32'h0, RESP_OKAY);
    foreach (gcase[k]) begin
      wr(OFF_TIMER1_CTRL, {24'h0, T1_SRC_OSC, 5'h0, gcase[k][2]}, RESP_OKAY);
      wr(OFF_GATE_CTRL, {31'h0, gcase[k][1]}, RESP_OKAY);
      GATE_IN <= gcase[k][0];
      wr(OFF_TIMER1_CNT, 32'h0, RESP_OKAY);
      burst(n, 1'b0);
      rd(OFF_TIMER1_CNT, (gcase[k][2] && (!gcase[k][1] || gcase[k][0])) ? {26'h0, n} : 34'h0);
    end
    rd(OFF_TIMER0_CNT, 34'h0);
    $display("test timer1 run and gate done");

    wr(OFF_TIMER1_CTRL, 32'hC1, RESP_OKAY);
    wr(OFF_GATE_CTRL, 32'h1, RESP_OKAY);
    for (int m = 0; m < 2; m++) begin
      GATE_IN <= 1'b0;
      pcount  <= 8'h80;
      pload   <= m[0];
      pstart  <= 1'b1;
      @(posedge REF_CLK);
      pstart  <= 1'b0;
      wr(OFF_TIMER1_CNT, 32'h0, RESP_OKAY);
      // Gate window stands in for the overflow toggling the gate
      GATE_IN <= 1'b1;
      repeat (500) @(posedge REF_CLK);
      GATE_IN <= 1'b0;
      while (pbusy) @(posedge REF_CLK);
      repeat (6) @(posedge REF_CLK);
      rd(OFF_TIMER1_CNT, {18'h0, ref_cnt});
      meas[m] = ref_cnt;
    end
    chk(meas[1] < meas[0], 1'b1);
    thr = ({1'b0, meas[0]} + {1'b0, meas[1]}) >> 1;
    chk(thr > meas[1] && thr < meas[0], 1'b1);
    $display("test time base done");

    wr(OFF_TIMER0_CFG, 32'h1, RESP_OKAY);
    wr(OFF_TIMER0_CNT, 32'h0, RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      wr(OFF_TIMER1_CTRL, {24'h0, 2'(s), 6'h01}, RESP_OKAY);
      wr(OFF_TIMER1_CNT, 32'h0, RESP_OKAY);
      GATE_IN <= 1'b1;
      repeat (8) begin
        TIMER0_PIN <= 1'b1;
        TIMER1_PIN <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        TIMER0_PIN <= 1'b0;
        TIMER1_PIN <= 1'b0;
        repeat (4) @(posedge REF_CLK);
      end
      GATE_IN <= 1'b0;
      rd(OFF_TIMER1_CNT, (s == 0) ? 34'd16 : (s == 1) ? 34'd64 : 34'd8);
    end
    rd(OFF_TIMER0_CNT, 34'd24);
    wr(OFF_TIMER0_CFG, 32'h0, RESP_OKAY);
    $display("test timer sources done");

    wr(OFF_TIMER1_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_SENSE_CTRL0, 32'hC1, RESP_OKAY);
    wr(OFF_TIMER0_CNT, 32'h0, RESP_OKAY);
    wr(OFF_EVENT_STAT, 32'h3, RESP_OKAY);
    burst(n, 1'b0);
    rd(OFF_EVENT_STAT, 34'h2);
    rd(OFF_TIMER0_CNT, {26'h0, n});
    wr(OFF_EVENT_STAT, 32'h2, RESP_OKAY);
    rd(OFF_EVENT_STAT, 34'h0);
    wr(OFF_TIMER0_CNT, 32'hFE, RESP_OKAY);
    burst(8'h03, 1'b0);
    rd(OFF_TIMER0_CNT, 34'h1);
    rd(OFF_EVENT_STAT, 34'h3);
    $display("test noise and overflow done");

    wr(OFF_SENSE_CTRL0, 32'h8D, RESP_OKAY);
    park <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    rd(OFF_SENSE_CTRL0, 34'h8F);
    park <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    rd(OFF_SENSE_CTRL0, 34'h8D);
    $display("test direction status done");
    end_sim();
  end
endmodule : capacitive_sense_mode_and_timer_select_bench
